// ==== adc_conversion_control.v ====
/*
  Control of a 10-bit sequential converter with sixteen multiplexed inputs:
  register file on Avalon-MM, normal and top-priority conversion sequencing,
  result storage, digital port reads of the analog pins, interrupt.
  Assumes an external multiplexer, sample-hold, DAC and comparator, and a
  host that halts the converter before standby and programs the bias setup.
*/
// Design decisions made here: register access over Avalon-MM and the register offsets.
// What this block does
// - Each conversion yields a 10-bit result by successive approximation.
// - Sixteen input channels share one engine through a multiplexer.
// - Every analog pin can also be read as a digital input.
// - Normal results land in sixteen upper/lower result byte pairs.
// - Top-priority results land in their own upper/lower pair.
// - Done flag, bit 7, is 0 until conversion completes, then 1; read-only.
// - Busy flag, bit 6, reads 1 during conversion, 0 when stopped.
// - Writing 1 to start begins conversion; 0 does nothing; reads 0.
// - Scan 0 with repeat 1 selects fixed-channel repeat mode.
// - Fixed repeat interrupts every 1, 4 or 8 conversions for codes 00/01/10.
`timescale 1ns/100ps
`include "adc_map.vh"

module adc_conversion_control #(
  parameter RES_BITS = 10,
  parameter NUM_CH = 16
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire avs_waitrequest_o,
  output reg [31:0] avs_readdata_o,
  output reg [1:0] avs_response_o,
  input wire cmp_i,
  input wire [NUM_CH-1:0] pin_level_i,
  output reg [3:0] mux_sel_o,
  output wire sample_o,
  output wire [RES_BITS-1:0] dac_o,
  output reg [7:0] accuracy_bias_setup_o,
  output reg idle_run_enable_o,
  output wire conversion_done_irq_o
);

  localparam [1:0] C_IDLE = 2'd0;
  localparam [1:0] C_NORMAL = 2'd1;
  localparam [1:0] C_TOP = 2'd2;

  // ----------------------------------------------------------------------
  // Bus slave: one wait state, access completes on the second edge
  // ----------------------------------------------------------------------
  reg ack;
  wire req = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ack & avs_byteenable_i[0];
  wire [7:0] wdat = avs_writedata_i[7:0];
  wire [7:0] adr = avs_address_i;

  assign avs_waitrequest_o = req & ~ack;

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ack <= 1'b0;
    else
      ack <= req & ~ack;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg scan_mode;
  reg repeat_mode;
  reg [1:0] irq_interval;
  reg normal_done_flag;
  reg normal_busy_flag;
  reg [3:0] chan_sel;
  reg scan8;
  reg [3:0] top_chan;
  reg top_pending;
  reg top_done_flag;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [RES_BITS-1:0] result_mem [0:NUM_CH-1];
  reg [RES_BITS-1:0] top_result;
  reg [NUM_CH-1:0] pin_meta;
  reg [NUM_CH-1:0] pin_sync;

  reg [1:0] state;
  reg normal_pending;
  reg [3:0] cur_ch;
  reg [2:0] itv_cnt;
  reg eng_start;
  wire eng_done;
  wire [RES_BITS-1:0] eng_result;

  wire start_wr = wr_go && adr == `ADC_OFS_MODE && wdat[`ADC_MODE_START];
  wire top_wr = wr_go && adr == `ADC_OFS_TOP_CTRL && wdat[`ADC_TOP_START];
  wire fixed_repeat = ~scan_mode & repeat_mode;
  // First channel of a scan group: groups of four, or of eight when scan8
  wire [3:0] scan_first = scan8 ? {chan_sel[3], 3'b000} : {chan_sel[3:2], 2'b00};
  wire at_last = ~scan_mode | (cur_ch == chan_sel);
  wire [2:0] itv_limit = (irq_interval == 2'b00) ? 3'd0 :
                         (irq_interval == 2'b01) ? 3'd3 : 3'd7;

  // Events of a completed normal pass or repeat interval, and of a top-priority conversion
  reg normal_event;
  reg top_event;

  // Synchroniser for the digital view of the analog pins
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_meta <= {NUM_CH{1'b0}};
      pin_sync <= {NUM_CH{1'b0}};
    end
    else
    begin
      pin_meta <= pin_level_i;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Software-written control fields
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scan_mode <= 1'b0;
      repeat_mode <= 1'b0;
      irq_interval <= 2'b00;
      chan_sel <= 4'h0;
      scan8 <= 1'b0;
      idle_run_enable_o <= 1'b0;
      top_chan <= 4'h0;
      irq_mask <= 2'b00;
      accuracy_bias_setup_o <= `ADC_BIAS_RESET;
    end
    else if (wr_go)
    begin
      case (adr)
        `ADC_OFS_MODE:
        begin
          scan_mode <= wdat[`ADC_MODE_SCAN];
          repeat_mode <= wdat[`ADC_MODE_REPEAT];
          irq_interval <= {wdat[`ADC_MODE_ITV_HI], wdat[`ADC_MODE_ITV_LO]};
        end
        `ADC_OFS_CHSEL:
        begin
          chan_sel <= wdat[3:0];
          scan8 <= wdat[`ADC_CHSEL_SCAN8];
          idle_run_enable_o <= wdat[`ADC_CHSEL_IDLE_RUN];
        end
        `ADC_OFS_TOP_CTRL:
          top_chan <= wdat[3:0];
        `ADC_OFS_IRQ_MASK:
          irq_mask <= wdat[1:0];
        `ADC_OFS_BIAS:
          // Bit 2 is read-only zero; the rest follow software
          accuracy_bias_setup_o <= wdat & ~`ADC_BIAS_RO_MASK;
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  // A top-priority request waits only for the conversion in flight, then
  // runs before the next normal channel; the normal sequence resumes after.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= C_IDLE;
      normal_pending <= 1'b0;
      top_pending <= 1'b0;
      cur_ch <= 4'h0;
      itv_cnt <= 3'd0;
      eng_start <= 1'b0;
      mux_sel_o <= 4'h0;
      normal_done_flag <= 1'b0;
      normal_busy_flag <= 1'b0;
      top_done_flag <= 1'b0;
      top_result <= {RES_BITS{1'b0}};
      normal_event <= 1'b0;
      top_event <= 1'b0;
    end
    else
    begin
      eng_start <= 1'b0;
      normal_event <= 1'b0;
      top_event <= 1'b0;
      if (start_wr)
      begin
        normal_pending <= 1'b1;
        normal_busy_flag <= 1'b1;
        normal_done_flag <= 1'b0;
        // Scan bit is written together with start, so take it from the bus
        cur_ch <= wdat[`ADC_MODE_SCAN] ? scan_first : chan_sel;
        itv_cnt <= 3'd0;
      end
      if (top_wr)
      begin
        top_pending <= 1'b1;
        top_done_flag <= 1'b0;
      end
      case (state)
        C_IDLE:
        begin
          if (top_pending)
          begin
            mux_sel_o <= top_chan;
            eng_start <= 1'b1;
            state <= C_TOP;
          end
          else if (normal_pending && !start_wr)
          begin
            mux_sel_o <= cur_ch;
            eng_start <= 1'b1;
            state <= C_NORMAL;
          end
        end
        C_NORMAL:
        begin
          if (eng_done)
          begin
            state <= C_IDLE;
            // A start written in this cycle restarts and must not be undone
            if (!start_wr && at_last)
            begin
              cur_ch <= scan_mode ? scan_first : chan_sel;
              if (!repeat_mode)
              begin
                normal_pending <= 1'b0;
                normal_busy_flag <= 1'b0;
                normal_done_flag <= 1'b1;
                normal_event <= 1'b1;
              end
              else if (fixed_repeat && itv_cnt != itv_limit)
                itv_cnt <= itv_cnt + 3'd1;
              else
              begin
                itv_cnt <= 3'd0;
                normal_done_flag <= 1'b1;
                normal_event <= 1'b1;
              end
            end
            else if (!start_wr)
              cur_ch <= cur_ch + 4'h1;
          end
        end
        C_TOP:
        begin
          if (eng_done)
          begin
            top_result <= eng_result;
            top_pending <= top_wr;
            top_done_flag <= 1'b1;
            top_event <= 1'b1;
            state <= C_IDLE;
          end
        end
        default:
          state <= C_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Result storage, one register per channel
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : g_result
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
          result_mem[g] <= {RES_BITS{1'b0}};
        else if (state == C_NORMAL && eng_done && mux_sel_o == g)
          result_mem[g] <= eng_result;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Interrupt: sticky status, write-one-to-clear, set wins over clear
  // ----------------------------------------------------------------------
  wire [1:0] irq_set = {top_event, normal_event};
  wire [1:0] irq_clr = (wr_go && adr == `ADC_OFS_IRQ_STATUS) ? wdat[1:0] : 2'b00;

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_status <= 2'b00;
    else
      irq_status <= (irq_status & ~irq_clr) | irq_set;
  end

  assign conversion_done_irq_o = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // Read data; result words hold the upper byte in [15:8], lower in [7:0]
  // ----------------------------------------------------------------------
  reg [31:0] next_readdata;
  reg next_err;
  wire [3:0] res_idx = adr[5:2];

  always @*
  begin
    next_readdata = 32'h0000_0000;
    next_err = 1'b0;
    if (adr >= `ADC_OFS_RESULT_BASE && adr[1:0] == 2'b00 && adr[7] == 1'b0)
      next_readdata[15:0] = {result_mem[res_idx][RES_BITS-1:RES_BITS-8],
                             result_mem[res_idx][1:0], 6'h00};
    else
    begin
      case (adr)
        `ADC_OFS_MODE:
          // Start always reads back zero
          next_readdata[7:0] = {normal_done_flag, normal_busy_flag, 1'b0,
                                irq_interval, repeat_mode, scan_mode, 1'b0};
        `ADC_OFS_CHSEL:
          next_readdata[7:0] = {1'b0, idle_run_enable_o, scan8, 1'b0, chan_sel};
        `ADC_OFS_BIAS:
          next_readdata[7:0] = accuracy_bias_setup_o;
        `ADC_OFS_IRQ_STATUS:
          next_readdata[1:0] = irq_status;
        `ADC_OFS_IRQ_MASK:
          next_readdata[1:0] = irq_mask;
        `ADC_OFS_PORT_IN:
          next_readdata[NUM_CH-1:0] = pin_sync;
        `ADC_OFS_TOP_CTRL:
          next_readdata[7:0] = {top_done_flag, top_pending, 2'b00, top_chan};
        `ADC_OFS_TOP_RESULT:
          next_readdata[15:0] = {top_result[RES_BITS-1:RES_BITS-8],
                                 top_result[1:0], 6'h00};
        default:
          next_err = 1'b1;
      endcase
    end
  end

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'b00;
    end
    else if (req && !ack)
    begin
      avs_readdata_o <= avs_read_i ? next_readdata : 32'h0000_0000;
      // Unmapped addresses answer with SLVERR and read as zero
      avs_response_o <= next_err ? 2'b10 : 2'b00;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------------
  adc_sar_engine #(
    .RES_BITS(RES_BITS)
  ) u_engine (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(eng_start),
    .cmp_i(cmp_i),
    .sample_o(sample_o),
    .dac_o(dac_o),
    .done_o(eng_done),
    .result_o(eng_result)
  );

endmodule // adc_conversion_control

// ==== adc_map.vh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  converter control block.
  Assumes a 10 MHz system clock and a byte-addressed Avalon-MM slave view.
*/
`ifndef ADC_MAP_VH
`define ADC_MAP_VH

// ----------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------
`define ADC_OFS_MODE 8'h00
`define ADC_OFS_CHSEL 8'h04
`define ADC_OFS_BIAS 8'h08
`define ADC_OFS_IRQ_STATUS 8'h0c
`define ADC_OFS_IRQ_MASK 8'h10
`define ADC_OFS_PORT_IN 8'h14
`define ADC_OFS_TOP_CTRL 8'h18
`define ADC_OFS_TOP_RESULT 8'h1c
`define ADC_OFS_RESULT_BASE 8'h40

// ----------------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------------
`define ADC_MODE_START 0
`define ADC_MODE_SCAN 1
`define ADC_MODE_REPEAT 2
`define ADC_MODE_ITV_LO 3
`define ADC_MODE_ITV_HI 4
`define ADC_MODE_BUSY 6
`define ADC_MODE_DONE 7

// Channel select fields
`define ADC_CHSEL_SCAN8 5
`define ADC_CHSEL_IDLE_RUN 6

// Top-priority control fields
`define ADC_TOP_START 5
`define ADC_TOP_BUSY 6
`define ADC_TOP_DONE 7

// Interrupt status / mask bits
`define ADC_IRQ_NORMAL 0
`define ADC_IRQ_TOP 1

// ----------------------------------------------------------------------
// Reset value and read-only mask of the bias setup
// ----------------------------------------------------------------------
`define ADC_BIAS_RESET 8'h38
`define ADC_BIAS_RO_MASK 8'h04

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ADC_CLK_NS 100
`define ADC_SAMPLE_NS 1000
`define ADC_SETTLE_NS 400
`define ADC_SAMPLE_CYC ((`ADC_SAMPLE_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_SETTLE_CYC ((`ADC_SETTLE_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

// ==== adc_sar_engine.v ====
/*
  One successive-approximation conversion: sample, then one trial per bit
  from the most significant down.
  Assumes an external sample-hold, DAC and comparator; the comparator output
  is asynchronous and is synchronised here.
*/
`timescale 1ns/100ps
`include "adc_map.vh"

module adc_sar_engine #(
  parameter RES_BITS = 10
) (
  input wire clk_i,
  input wire nrst_i,
  input wire start_i,
  input wire cmp_i,
  output reg sample_o,
  output reg [RES_BITS-1:0] dac_o,
  output reg done_o,
  output reg [RES_BITS-1:0] result_o
);

  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_SAMPLE = 2'd1;
  localparam [1:0] S_TRIAL = 2'd2;
  localparam integer SAMPLE_INT = `ADC_SAMPLE_CYC;
  // Settling must also cover the two synchroniser stages
  localparam integer SETTLE_INT = `ADC_SETTLE_CYC + 2;
  localparam [7:0] SAMPLE_CYC = SAMPLE_INT[7:0];
  localparam [7:0] SETTLE_CYC = SETTLE_INT[7:0];

  reg [1:0] state;
  reg [7:0] wait_cnt;
  reg [3:0] bit_idx;
  reg cmp_meta;
  reg cmp_sync;

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end
    else
    begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Sequential conversion
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= S_IDLE;
      wait_cnt <= 8'h00;
      bit_idx <= 4'h0;
      sample_o <= 1'b0;
      dac_o <= {RES_BITS{1'b0}};
      done_o <= 1'b0;
      result_o <= {RES_BITS{1'b0}};
    end
    else
    begin
      done_o <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start_i)
          begin
            state <= S_SAMPLE;
            sample_o <= 1'b1;
            wait_cnt <= SAMPLE_CYC;
          end
        end
        S_SAMPLE:
        begin
          if (wait_cnt == 8'h01)
          begin
            sample_o <= 1'b0;
            state <= S_TRIAL;
            bit_idx <= RES_BITS[3:0] - 4'h1;
            dac_o <= {1'b1, {(RES_BITS-1){1'b0}}};
            wait_cnt <= SETTLE_CYC;
          end
          else
            wait_cnt <= wait_cnt - 8'h01;
        end
        S_TRIAL:
        begin
          if (wait_cnt == 8'h01)
          begin
            // Comparator high means input is above the trial level: keep bit
            if (bit_idx == 4'h0)
            begin
              result_o <= {dac_o[RES_BITS-1:1], cmp_sync};
              done_o <= 1'b1;
              state <= S_IDLE;
            end
            else
            begin
              dac_o[bit_idx] <= cmp_sync;
              dac_o[bit_idx - 4'h1] <= 1'b1;
              bit_idx <= bit_idx - 4'h1;
              wait_cnt <= SETTLE_CYC;
            end
          end
          else
            wait_cnt <= wait_cnt - 8'h01;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

endmodule // adc_sar_engine

// ==== adc_conversion_control_asserts.sv ====
/*
  Port checker for the converter control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module adc_conversion_control_asserts #(
  parameter RES_BITS = 10,
  parameter NUM_CH = 16
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire avs_waitrequest_o,
  input wire [31:0] avs_readdata_o,
  input wire [1:0] avs_response_o,
  input wire [3:0] mux_sel_o,
  input wire sample_o,
  input wire [7:0] accuracy_bias_setup_o,
  input wire conversion_done_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire rd_ok = avs_read_i && !avs_waitrequest_o;
  wire wr_ok = avs_write_i && !avs_waitrequest_o;
  wire res_addr = avs_address_i >= 8'h40 && avs_address_i < 8'h80;
  wire mapped = avs_address_i[1:0] == 2'b00 && (avs_address_i <= 8'h1c || res_addr);
  reg [7:0] wd_q;
  // Write data of the accepted cycle, kept for the following cycle
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      wd_q <= 8'h00;
    else
      wd_q <= avs_writedata_i[7:0];
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_start_reads0;
    rd_ok && avs_address_i == 8'h00 |-> avs_readdata_o[0] == 1'b0;
  endproperty
  property p_start_runs;
    wr_ok && avs_address_i == 8'h00 && avs_writedata_i[0] && avs_byteenable_i[0] |-> ##[1:160] sample_o;
  endproperty
  property p_bias_ro;
    accuracy_bias_setup_o[2] == 1'b0;
  endproperty
  property p_bias_wr;
    wr_ok && avs_address_i == 8'h08 && avs_byteenable_i[0] |=> accuracy_bias_setup_o == (wd_q & 8'hfb);
  endproperty
  property p_sample_len;
    $rose(sample_o) |-> sample_o [*8] ##1 sample_o [*2] ##1 !sample_o;
  endproperty
  property p_mux_hold;
    sample_o && $past(sample_o) |-> $stable(mux_sel_o);
  endproperty
  property p_trial_gap;
    $fell(sample_o) |-> !sample_o [*8];
  endproperty
  property p_unmapped;
    rd_ok && !mapped |-> avs_readdata_o == 32'h0 && avs_response_o == 2'b10;
  endproperty
  property p_res_fmt;
    rd_ok && res_addr |-> avs_readdata_o[5:0] == 6'h00 && avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_start_reads0: assert property (p_start_reads0)
    else $error("start bit read back as one");
  a_start_runs: assert property (p_start_runs)
    else $error("start write did not begin sampling");
  a_bias_ro: assert property (p_bias_ro)
    else $error("bias bit 2 not zero");
  a_bias_wr: assert property (p_bias_wr)
    else $error("bias output differs from written value");
  a_sample_len: assert property (p_sample_len)
    else $error("sample window not ten cycles");
  a_mux_hold: assert property (p_mux_hold)
    else $error("channel select moved during sampling");
  a_trial_gap: assert property (p_trial_gap)
    else $error("sampling restarted during trials");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  a_res_fmt: assert property (p_res_fmt)
    else $error("result word has stray bits");
  c_start: cover property (wr_ok && avs_address_i == 8'h00 && avs_writedata_i[0]);
  c_irq: cover property ($rose(conversion_done_irq_o));
  c_unmapped: cover property (rd_ok && !mapped);
endmodule // adc_conversion_control_asserts

// ==== adc_front_model.sv ====
/*
  Model of the analog mux, sample-hold and comparator.
  Assumes channel n carries the level n*61+7; the comparator answers
  after CMP_DELAY_NS so slow settling can be tried.
*/
`timescale 1ns/100ps
module adc_front_model #(
  parameter CMP_DELAY_NS = 0
) (
  input wire clk_i,
  input wire [3:0] mux_sel_i,
  input wire sample_i,
  input wire [9:0] dac_i,
  output wire cmp_o
);
  reg [9:0] held = 10'h000;
  // Hold tracks the selected channel only while sampling
  always @(posedge clk_i)
    if (sample_i)
      held <= 10'(mux_sel_i * 61 + 7);
  assign #(CMP_DELAY_NS) cmp_o = held >= dac_i;
endmodule // adc_front_model

// ==== adc_conversion_control_tb.sv ====
/*
  Self-checking bench for the converter control block.
  Assumes the front model as far side and Avalon-MM access with one wait cycle.
*/
`timescale 1ns/100ps
module adc_conversion_control_tb;
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [7:0] avs_address_i = 8'h00;
  reg avs_read_i = 1'b0;
  reg avs_write_i = 1'b0;
  reg [31:0] avs_writedata_i = 32'h0;
  reg [3:0] avs_byteenable_i = 4'h0;
  reg [15:0] pin_level_i = 16'h3c5a;
  wire avs_waitrequest_o, cmp_i, sample_o, idle_run_enable_o, conversion_done_irq_o;
  wire [31:0] avs_readdata_o;
  wire [1:0] avs_response_o;
  wire [3:0] mux_sel_o;
  wire [9:0] dac_o;
  wire [7:0] accuracy_bias_setup_o;
  integer error_cnt = 0, check_count = 0, conv_cnt = 0, base, i, n, ex;
  reg [31:0] rd;
  reg [1:0] rsp;
  always #50 clk_i = ~clk_i;
  always @(negedge sample_o) conv_cnt = conv_cnt + 1;
  adc_conversion_control dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o), .cmp_i(cmp_i),
    .pin_level_i(pin_level_i), .mux_sel_o(mux_sel_o), .sample_o(sample_o), .dac_o(dac_o),
    .accuracy_bias_setup_o(accuracy_bias_setup_o), .idle_run_enable_o(idle_run_enable_o),
    .conversion_done_irq_o(conversion_done_irq_o));
  adc_front_model #(.CMP_DELAY_NS(150)) fe_u (.clk_i(clk_i), .mux_sel_i(mux_sel_o),
    .sample_i(sample_o), .dac_i(dac_o), .cmp_o(cmp_i));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task check(input [31:0] seen, input [31:0] exp, input string what);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: %0s seen %h expected %h", $time, what, seen, exp);
    end
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task acc(input [7:0] a, input [31:0] d, input [3:0] be, input w);
    integer wt;
  begin
    wt = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
    begin
      wt = wt + 1;
      @(posedge clk_i);
    end
    rd = avs_readdata_o;
    rsp = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
    check(wt, 32'd1, "wait states");
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    acc(a, d, 4'hf, 1'b1);
  endtask
  task rdc(input [7:0] a, input [31:0] exp, input string what);
  begin
    acc(a, 32'h0, 4'hf, 1'b0);
    check(rd, exp, what);
  end
  endtask
  task wirq;
  begin
    n = 0;
    while (conversion_done_irq_o !== 1'b1 && n < 3000)
    begin
      n = n + 1;
      @(posedge clk_i);
    end
    check({31'h0, conversion_done_irq_o}, 32'h1, "irq wait");
  end
  endtask
  // Result word: upper byte holds bits 9:2, bits 7:6 hold bits 1:0
  function [31:0] rw(input integer ch);
    reg [9:0] v;
  begin
    v = 10'(ch * 61 + 7);
    rw = {16'h0, v, 6'h00};
  end
  endfunction
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rdc(8'h00, 32'h0, "mode reset");
    rdc(8'h08, 32'h38, "bias reset");
    rdc(8'h2c, 32'h0, "unmapped data");
    check({30'h0, rsp}, 32'h2, "unmapped resp");
    wr(8'h08, 32'hff);
    rdc(8'h08, 32'hfb, "bias bit2");
    acc(8'h08, 32'h00, 4'he, 1'b1);
    rdc(8'h08, 32'hfb, "bias lane off");
    wr(8'h08, 32'h58);
    check({24'h0, accuracy_bias_setup_o}, 32'h58, "bias out");
    $display("test bias done");
    wr(8'h04, 32'h05);
    wr(8'h10, 32'h01);
    wr(8'h00, 32'h01);
    rdc(8'h00, 32'h40, "busy");
    wirq;
    rdc(8'h00, 32'h80, "done");
    rdc(8'h54, rw(5), "result 5");
    rdc(8'h0c, 32'h1, "status");
    wr(8'h10, 32'h00);
    check({31'h0, conversion_done_irq_o}, 32'h0, "masked");
    wr(8'h10, 32'h01);
    check({31'h0, conversion_done_irq_o}, 32'h1, "unmasked");
    wr(8'h0c, 32'h01);
    check({31'h0, conversion_done_irq_o}, 32'h0, "cleared");
    wr(8'h00, 32'h00);
    rdc(8'h00, 32'h80, "zero start");
    $display("test single done");
    wr(8'h04, 32'h03);
    wr(8'h00, 32'h03);
    wirq;
    rdc(8'h00, 32'h82, "scan done");
    for (i = 0; i < 4; i = i + 1)
      rdc(8'(8'h40 + 4 * i), rw(i), "scan result");
    wr(8'h0c, 32'h01);
    wr(8'h04, 32'h29);
    wr(8'h00, 32'h03);
    wirq;
    for (i = 8; i < 10; i = i + 1)
      rdc(8'(8'h40 + 4 * i), rw(i), "scan8 result");
    wr(8'h0c, 32'h01);
    $display("test scan done");
    wr(8'h04, 32'h09);
    // Interval code 11 is never programmed
    for (i = 0; i < 3; i = i + 1)
    begin
      ex = (i == 0) ? 1 : 4 * i;
      base = conv_cnt;
      wr(8'h00, 32'h05 | (i << 3));
      wirq;
      check(conv_cnt - base, ex, "first interval");
      base = conv_cnt;
      wr(8'h0c, 32'h01);
      wirq;
      check(conv_cnt - base, ex, "next interval");
      wr(8'h00, 32'h00);
      acc(8'h00, 32'h0, 4'hf, 1'b0);
      for (n = 0; n < 60 && rd[6] !== 1'b0; n = n + 1)
        acc(8'h00, 32'h0, 4'hf, 1'b0);
      check({31'h0, rd[6]}, 32'h0, "repeat stop");
      wr(8'h0c, 32'h01);
    end
    $display("test repeat done");
    pin_level_i <= 16'ha5c3;
    repeat (3) @(posedge clk_i);
    rdc(8'h14, 32'ha5c3, "pins");
    wr(8'h10, 32'h03);
    wr(8'h18, 32'h2c);
    wirq;
    rdc(8'h0c, 32'h2, "top status");
    rdc(8'h1c, rw(12), "top result");
    rdc(8'h00, 32'h80, "halted before idle run");
    wr(8'h04, 32'h40);
    check({31'h0, idle_run_enable_o}, 32'h1, "idle run");
    $display("test top done");
    summarize;
  end
  initial
  begin
    #3000000;
    error_cnt = error_cnt + 1;
    $display("wrong value at %0t: watchdog", $time);
    summarize;
  end
endmodule // adc_conversion_control_tb
bind adc_conversion_control adc_conversion_control_asserts #(.RES_BITS(RES_BITS), .NUM_CH(NUM_CH)) chk_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
  .mux_sel_o(mux_sel_o), .sample_o(sample_o), .accuracy_bias_setup_o(accuracy_bias_setup_o),
  .conversion_done_irq_o(conversion_done_irq_o));
